// file: hw/rpt_div.v
// tick divider: one pulse every term+1 enabled steps
`timescale 1ns/10ps
`default_nettype none
module rpt_div (
  input wire core_clk,
  input wire srst,
  input wire step,
  input wire [4:0] term,
  output reg tick_r
);
  reg [4:0] cnt_r;

  // counter wraps at term; term is compared live, so a change applies to the current count, wrapping at the next step if already past
  always @(posedge core_clk) begin
    if (srst) begin
      cnt_r <= 5'h0_000;
      tick_r <= 1'b0;
    end else begin
      tick_r <= 1'b0;
      if (step) begin
        if (cnt_r >= term) begin
          cnt_r <= 5'h0_000;
          tick_r <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 5'h0_001;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: hw/rpt_regs.vh
// timing constants and field widths for the rx polling timebase
`ifndef RPT_REGS_VH
`define RPT_REGS_VH
`define RPT_CLK_PERIOD_NS 10
`define RPT_BASIC_DIV 16
`define RPT_BASIC_TERM 5'h0_00F
`define RPT_EXT_BASE 5'h0_008
`define RPT_SLEEP_UNIT 1024
`define RPT_PLL_HALF_PERIODS 1597
`define RPT_PLL_CYCLES ((`RPT_PLL_HALF_PERIODS * `RPT_BASIC_DIV) / 2)
`define RPT_SIG_BR0 18'h0_0372
`define RPT_SIG_BR1 18'h0_01F2
`define RPT_SIG_BR2 18'h0_0132
`define RPT_SIG_BR3 18'h0_00D2
`define RPT_NBIT_STEP 5'h0_006
`endif

// file: hw/rpt_timebase.v
// rx polling timebase: basic and extended clock ticks plus polling sequencer
`timescale 1ns/10ps
`default_nettype none
`include "rpt_regs.vh"
module rpt_timebase #(
  parameter [17:0] PLL_STARTUP_CYCLES = `RPT_PLL_CYCLES
) (
  input wire core_clk,
  input wire srst,
  input wire poll_en,
  input wire rx_direct,
  input wire limit_extension_select,
  input wire [1:0] baud_range_select,
  input wire [4:0] sleep_time,
  input wire [4:0] sleep_multiplier,
  input wire [1:0] bit_check_sel,
  input wire [7:0] lim_min,
  input wire [7:0] lim_max,
  input wire slicer_data,
  output reg basic_tick_r,
  output reg ext_tick_r,
  output reg sleep_active_r,
  output reg pll_startup_r,
  output reg sig_startup_r,
  output reg bit_check_r,
  output reg rx_active_r,
  output reg bit_check_fail_r
);
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_SLEEP = 3'h1;
  localparam [2:0] ST_PLL = 3'h2;
  localparam [2:0] ST_SIG = 3'h3;
  localparam [2:0] ST_BCHK = 3'h4;
  localparam [2:0] ST_RX = 3'h5;

  wire basic_tick;
  wire ext_tick;
  wire [4:0] ext_term;
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [19:0] tmr_r;
  reg [19:0] load_val;
  reg load;
  reg [7:0] ivl_r;
  reg [4:0] edge_cnt_r;
  reg seen_r;
  reg data_prev_r;
  reg fail;
  reg pass;
  wire [4:0] edges_needed;
  wire data_edge;
  wire [9:0] sleep_mul;
  wire [19:0] sleep_prod;
  wire [17:0] sig_val;

  // basic clock: crystal divided by sixteen
  rpt_div u_basic (
    .core_clk(core_clk),
    .srst(srst),
    .step(1'b1),
    .term(`RPT_BASIC_TERM),
    .tick_r(basic_tick)
  );

  // extended clock ratio from baud range and limit extension
  assign ext_term = ((`RPT_EXT_BASE << limit_extension_select) >> baud_range_select) - 5'h0_001;
  rpt_div u_ext (
    .core_clk(core_clk),
    .srst(srst),
    .step(basic_tick),
    .term(ext_term),
    .tick_r(ext_tick)
  );

  // sleep length in basic periods; an all-zero product still sleeps one period
  // full ten-bit product; the timer is twenty bits so the largest setting is honoured
  assign sleep_mul = sleep_time * sleep_multiplier;
  assign sleep_prod = {sleep_mul, 10'h000};
  assign sig_val = (baud_range_select == 2'h0) ? `RPT_SIG_BR0 :
                   (baud_range_select == 2'h1) ? `RPT_SIG_BR1 :
                   (baud_range_select == 2'h2) ? `RPT_SIG_BR2 : `RPT_SIG_BR3;
  // six edge intervals (three signal periods) per step of bit_check_sel
  assign edges_needed = {bit_check_sel, 1'b0} + bit_check_sel * 3'h4;
  assign data_edge = slicer_data ^ data_prev_r;

  // bit-check verdict from edge interval limits measured in extended periods
  always @* begin
    pass = 1'b0;
    fail = 1'b0;
    if (state_r == ST_BCHK) begin
      if (ivl_r > lim_max) begin
        fail = 1'b1;
      end else if (data_edge && seen_r) begin
        if (ivl_r < lim_min) begin
          fail = 1'b1;
        end else if (edge_cnt_r + 5'h0_001 >= edges_needed) begin
          pass = 1'b1;
        end
      end
    end
  end

  // sequencer next state and timer reload
  always @* begin
    state_nxt = state_r;
    load = 1'b0;
    load_val = 20'h0_0000;
    case (state_r)
      ST_IDLE: begin
        if (rx_direct) begin
          state_nxt = ST_PLL;
          load = 1'b1;
          load_val = {2'h0, PLL_STARTUP_CYCLES} - 20'h0_0001;
        end else if (poll_en) begin
          state_nxt = ST_SLEEP;
          load = 1'b1;
          load_val = (sleep_prod == 20'h0_0000) ? 20'h0_0000 : sleep_prod - 20'h0_0001;
        end
      end
      ST_SLEEP: begin
        if (!poll_en) begin
          state_nxt = ST_IDLE;
        end else if (basic_tick && tmr_r == 20'h0_0000) begin
          state_nxt = ST_PLL;
          load = 1'b1;
          load_val = {2'h0, PLL_STARTUP_CYCLES} - 20'h0_0001;
        end
      end
      ST_PLL: begin
        if (tmr_r == 20'h0_0000) begin
          state_nxt = ST_SIG;
          load = 1'b1;
          load_val = {2'h0, sig_val} - 20'h0_0001;
        end
      end
      ST_SIG: begin
        if (basic_tick && tmr_r == 20'h0_0000) begin
          // direct receive and N=0 skip the bit check
          state_nxt = (rx_direct || bit_check_sel == 2'h0) ? ST_RX : ST_BCHK;
        end
      end
      ST_BCHK: begin
        if (pass) begin
          state_nxt = ST_RX;
        end else if (fail) begin
          state_nxt = poll_en ? ST_SLEEP : ST_IDLE;
          load = 1'b1;
          load_val = (sleep_prod == 20'h0_0000) ? 20'h0_0000 : sleep_prod - 20'h0_0001;
        end
      end
      ST_RX: begin
        if (!poll_en && !rx_direct) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // state, timer and edge tracking; pll counts core cycles so the half period is exact
  always @(posedge core_clk) begin
    if (srst) begin
      state_r <= ST_IDLE;
      tmr_r <= 20'h0_0000;
      ivl_r <= 8'h00;
      edge_cnt_r <= 5'h0_000;
      seen_r <= 1'b0;
      data_prev_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      data_prev_r <= slicer_data;
      if (load) begin
        tmr_r <= load_val;
      end else if (tmr_r != 20'h0_0000 && (state_r == ST_PLL || basic_tick)) begin
        tmr_r <= tmr_r - 20'h0_0001;
      end
      if (state_r != ST_BCHK) begin
        ivl_r <= 8'h00;
        edge_cnt_r <= 5'h0_000;
        seen_r <= 1'b0;
      end else if (data_edge) begin
        ivl_r <= 8'h00;
        seen_r <= 1'b1;
        if (seen_r) begin
          edge_cnt_r <= edge_cnt_r + 5'h0_001;
        end
      end else if (ext_tick && ivl_r != 8'hFF) begin
        ivl_r <= ivl_r + 8'h01; // saturate at FF; a dead input times out only while lim_max is below FF
      end
    end
  end

  // registered outputs
  always @(posedge core_clk) begin
    if (srst) begin
      basic_tick_r <= 1'b0;
      ext_tick_r <= 1'b0;
      sleep_active_r <= 1'b0;
      pll_startup_r <= 1'b0;
      sig_startup_r <= 1'b0;
      bit_check_r <= 1'b0;
      rx_active_r <= 1'b0;
      bit_check_fail_r <= 1'b0;
    end else begin
      basic_tick_r <= basic_tick;
      ext_tick_r <= ext_tick;
      sleep_active_r <= (state_nxt == ST_SLEEP);
      pll_startup_r <= (state_nxt == ST_PLL);
      sig_startup_r <= (state_nxt == ST_SIG);
      bit_check_r <= (state_nxt == ST_BCHK);
      rx_active_r <= (state_nxt == ST_RX);
      bit_check_fail_r <= fail;
    end
  end
endmodule
`default_nettype wire

// file: tb/rpt_slicer_model.sv
// slicer stand-in that toggles its data line at a fixed edge spacing
`timescale 1ns/10ps
`default_nettype none
module rpt_slicer_model #(parameter int HALF = 64) (
  input wire logic core_clk,
  input wire logic en,
  output logic data = 1'b0
);
  int c = 0;
  // no signal means a quiet line, so the bit check runs out of time
  always @(posedge core_clk) begin
    c <= (c == HALF - 1) ? 0 : c + 1;
    if (en && c == HALF - 1) begin
      data <= ~data;
    end
  end
endmodule
`default_nettype wire

// file: tb/rpt_timebase_chk.sv
// checker for basic tick spacing and polling phase order
`timescale 1ns/10ps
`default_nettype none
module rpt_timebase_chk #(parameter [17:0] PLL_STARTUP_CYCLES = 18'h0_0064) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic poll_en,
  input wire logic basic_tick_r,
  input wire logic sleep_active_r,
  input wire logic pll_startup_r,
  input wire logic sig_startup_r,
  input wire logic bit_check_r,
  input wire logic rx_active_r,
  input wire logic bit_check_fail_r
);
  int pc = 0;
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // pll phase length counter, cleared while the phase is low
  always @(posedge core_clk) begin
    pc <= pll_startup_r ? pc + 1 : 0;
  end
  a_basic_period: assert property (basic_tick_r |-> ##16 basic_tick_r) else $error("basic period");
  a_basic_gap: assert property (basic_tick_r |=> !basic_tick_r [*8]) else $error("basic gap");
  a_pll_len: assert property ($fell(pll_startup_r) |-> pc == PLL_STARTUP_CYCLES) else $error("pll len");
  a_pll_next: assert property ($fell(pll_startup_r) |-> sig_startup_r) else $error("after pll");
  a_sig_next: assert property ($fell(sig_startup_r) |-> bit_check_r || rx_active_r) else $error("after sig");
  a_chk_exit: assert property ($fell(bit_check_r) |-> rx_active_r || sleep_active_r || !poll_en) else $error("exit");
  a_fail_pulse: assert property (bit_check_fail_r |=> !bit_check_fail_r) else $error("fail pulse");
  a_fail_ends_chk: assert property (bit_check_fail_r |-> $fell(bit_check_r)) else $error("fail outside check");
  a_sleep_next: assert property ($fell(sleep_active_r) |-> pll_startup_r || !poll_en) else $error("after sleep");
  a_one_hot: assert property ($onehot0({sleep_active_r, pll_startup_r, sig_startup_r, bit_check_r, rx_active_r}))
    else $error("phases");
  c_rx: cover property ($rose(rx_active_r));
  c_fail: cover property (bit_check_fail_r);
  c_pll: cover property ($fell(pll_startup_r));
endmodule
bind rpt_timebase rpt_timebase_chk #(.PLL_STARTUP_CYCLES(PLL_STARTUP_CYCLES)) u_chk (.core_clk, .srst, .poll_en,
  .basic_tick_r, .sleep_active_r, .pll_startup_r, .sig_startup_r, .bit_check_r, .rx_active_r, .bit_check_fail_r);
`default_nettype wire

// file: tb/rpt_timebase_tb.sv
// self-checking bench for the rx polling timebase
`timescale 1ns/10ps
`default_nettype none
module rpt_timebase_tb;
  localparam int PLL = 100;
  logic core_clk = 0, srst = 1, poll_en = 0, rx_direct = 0, limit_extension_select = 0, sd_en = 0;
  logic [1:0] baud_range_select = 2'h3, bit_check_sel = 2'h1;
  logic [4:0] sleep_time = 5'h01, sleep_multiplier = 5'h01;
  logic [7:0] lim_min = 8'h02, lim_max = 8'h06;
  wire slicer_data, basic_tick_r, ext_tick_r, sleep_active_r, pll_startup_r, sig_startup_r, bit_check_r;
  wire rx_active_r, bit_check_fail_r;
  wire [7:0] ph = {bit_check_fail_r, rx_active_r, bit_check_r, sig_startup_r, pll_startup_r, sleep_active_r,
    ext_tick_r, basic_tick_r};
  int fails = 0, cmp_count = 0, cyc = 0, n;
  always #5 core_clk = ~core_clk;
  rpt_timebase #(.PLL_STARTUP_CYCLES(18'(PLL))) u_rpt_timebase (.core_clk, .srst, .poll_en, .rx_direct,
    .limit_extension_select, .baud_range_select, .sleep_time, .sleep_multiplier, .bit_check_sel, .lim_min,
    .lim_max, .slicer_data, .basic_tick_r, .ext_tick_r, .sleep_active_r, .pll_startup_r, .sig_startup_r,
    .bit_check_r, .rx_active_r, .bit_check_fail_r);
  rpt_slicer_model u_rpt_slicer_model (.core_clk, .en(sd_en), .data(slicer_data));
  task results;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // hang guard, well above the longest poll sequence
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin fails++; results; end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin fails++; $display("FAIL %0t got %0h exp %0h", $time, got, exp); end
  endtask
  task chkr(input int got, input int lo, input int hi);
    cmp_count++;
    if (got < lo || got > hi) begin fails++; $display("FAIL %0t got %0h exp %0h", $time, got, lo); end
  endtask
  // bounded waits: cycles until phase bit k rises, and cycles it stays up
  task wt(input int k, output int c);
    c = 0;
    while (ph[k] !== 1'b1 && c < 40000) begin @(negedge core_clk); c++; end
  endtask
  task ln(input int k, output int c);
    c = 0;
    while (ph[k] === 1'b1 && c < 40000) begin @(negedge core_clk); c++; end
  endtask
  task t_ext;
    wt(0, n); @(negedge core_clk); wt(0, n); chk(n + 1, 16);
    for (int i = 0; i < 8; i++) begin
      {limit_extension_select, baud_range_select} = 3'(i);
      wt(1, n); @(negedge core_clk); wt(1, n); @(negedge core_clk); wt(1, n);
      chk(n + 1, ((i[2] ? 16 : 8) >> i[1:0]) * 16);
    end
    {limit_extension_select, baud_range_select} = 3'h3;
  endtask
  task t_direct;
    rx_direct = 1;
    wt(3, n); ln(3, n); chk(n, PLL);
    ln(4, n); chk(rx_active_r, 1);
    rx_direct = 0;
    repeat (2) @(negedge core_clk);
    chk(ph[7:2], 0);
  endtask
  // polling with a clean signal, then with none, then with the bit check skipped
  task t_poll;
    sd_en = 1; poll_en = 1;
    wt(2, n); ln(2, n); chkr(n, 16368, 16400);
    chk(pll_startup_r, 1);
    wt(5, n); ln(5, n); chkr(n, 384, 448);
    chk(rx_active_r, 1);
    poll_en = 0; sd_en = 0; sleep_time = 5'h00; bit_check_sel = 2'h2;
    repeat (2) @(negedge core_clk);
    poll_en = 1;
    wt(7, n); @(negedge core_clk);
    chk({bit_check_fail_r, sleep_active_r}, 1);
    // edges every four extended periods now come too early for the lower limit
    lim_min = 8'h06;
    sd_en = 1;
    wt(7, n);
    chk(bit_check_fail_r, 1);
    lim_min = 8'h02;
    bit_check_sel = 2'h0;
    wt(4, n); ln(4, n); chk({bit_check_r, rx_active_r}, 1);
    poll_en = 0;
  endtask
  initial begin
    repeat (12) @(negedge core_clk);
    srst = 0;
    t_ext;
    t_direct;
    t_poll;
    results;
  end
endmodule
`default_nettype wire
